// ### rsq_defs.svh
/*
 * Constants of the reading store and error queue: capacities, widths, reset values and codes.
 * Assumes it is included once by bare name from every file that needs it.
 */
`ifndef RSQ_DEFS_SVH
`define RSQ_DEFS_SVH
`define RSQ_STORE_DEPTH 11'd2000
`define RSQ_CNT_W 11
`define RSQ_CNT_DEF 11'd100
`define RSQ_CNT_MIN 11'd1
`define RSQ_RDG_W 24
`define RSQ_BUF_DEPTH 16
`define RSQ_ERR_DEPTH 5'd20
`define RSQ_ERR_AW 5
`define RSQ_ERR_W 16
`define RSQ_ERR_OVF 16'hfea2
`define RSQ_ERR_NONE 16'h0000
`define RSQ_BAND_W 14
`define RSQ_BAND_DEF 14'h000a
`define RSQ_PCT_SCALE 48'h0000_0000_2710
`define RSQ_HOLD_PREV 2'h2
`endif

// ### rsq_pkg.sv
/*
 * Types of the reading store and error queue: the error event carrier and the state record.
 * Assumes rsq_defs.svh is compiled with it.
 */
`include "rsq_defs.svh"
package rsq_pkg;
	typedef logic signed [`RSQ_RDG_W-1:0] rsq_rdg_t;
	typedef struct packed {
		logic vld;
		logic [`RSQ_ERR_W-1:0] code;
	} rsq_err_ev_t;
	typedef struct packed {
		logic cap_on;
		logic [`RSQ_CNT_W-1:0] cnt;
		logic [`RSQ_CNT_W-1:0] wr;
		logic [`RSQ_CNT_W-1:0] rd;
		logic [`RSQ_CNT_W-1:0] rev;
		logic fvld;
		logic binit;
		logic [`RSQ_BAND_W-1:0] band;
		rsq_rdg_t h1;
		rsq_rdg_t h2;
		logic [1:0] hn;
		logic held;
		rsq_rdg_t hval;
		logic beep;
		logic [`RSQ_ERR_AW-1:0] e_head;
		logic [`RSQ_ERR_AW-1:0] e_cnt;
		logic [`RSQ_ERR_W-1:0] e_out;
	} rsq_state_t;
endpackage

// ### rsq_top.sv
/*
 * Reading store with capture count, capture indicator and review; hold-mode stable detector;
 * error queue with overflow marking. Also holds the 16-word input buffer module.
 * Assumes one clock, synchronous inputs, and a synchronous active-low power-on reset.
 */
// Function
// [RQ1] Store up to 2000 readings, oldest out first.
// [RQ2] Reading store is empty after reset.
// [RQ3] Capture key stores readings up to count.
// [RQ4] Reading count returns to 100 at reset.
// [RQ5] Memory indicator lit while capture is storing.
// [RQ6] Review starts at oldest, steps forward or back.
// [RQ7] Arm command starts storing following readings.
// [RQ8] Answer fetch with readings, count with total.
// [RQ9] Count is changed only from panel entry.
// [RQ10] Stable when three readings lie within band.
// [RQ11] Stable reading beeps and freezes value.
// [RQ12] Hold band defaults to 0.1 percent.
// [RQ13] Startup setting keeps saved band or default.
// [RQ14] Error indicator lit while errors are queued.
// [RQ15] Queue holds 20 errors, oldest read first.
// [RQ16] Overflow replaces newest entry with -350 code.
// [RQ17] Indicator off once errors are read out.
// [RQ18] Empty queue read returns the no-error code.
// [RQ19] Queue empties at reset and clear-status.
// [RQ20] Count clamped to 1..2000; capture clears store.
// [RQ21] Each read removes the entry it returns.
`timescale 1ns/1ps
`include "rsq_defs.svh"
module rsq_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk_i, // System clock.
	input wire logic rst_n_i, // Synchronous reset, active low.
	input wire logic flush_i, // Drops every held word.
	input wire logic in_valid_i, // Word offered.
	output logic in_ready_o, // Room for a word.
	input wire logic [W-1:0] in_data_i, // Offered word.
	output logic out_valid_o, // Word available.
	input wire logic out_ready_i, // Drain takes the word.
	output logic [W-1:0] out_data_o // Oldest word.
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} rsq_fptr_t;
	rsq_fptr_t s_reg, s_next;
	logic [W-1:0] mem [DEPTH];
	logic push, pop;

	// Full and empty come straight from the pointer distance.
	assign in_ready_o = (s_reg.wp - s_reg.rp) != (AW+1)'(DEPTH);
	assign out_valid_o = s_reg.wp != s_reg.rp;
	assign out_data_o = mem[s_reg.rp[AW-1:0]];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Pointer advance; a flush wins over both sides.
	always_comb
	begin
		s_next = s_reg;
		if (push)
			s_next.wp = s_reg.wp + 1'b1;
		if (pop)
			s_next.rp = s_reg.rp + 1'b1;
		if (flush_i)
			s_next = '0;
	end

	// Pointer state register.
	always_ff @(posedge core_clk_i)
		if (!rst_n_i)
			s_reg <= '0;
		else
			s_reg <= s_next;

	// Word storage, no reset needed.
	always_ff @(posedge core_clk_i)
		if (push)
			mem[s_reg.wp[AW-1:0]] <= in_data_i;
endmodule

module rsq_top (
	input wire logic core_clk_i, // System clock, 200 MHz.
	input wire logic rst_n_i, // Power-on reset, active low.
	input wire logic rdg_valid_i, // New reading offered.
	output logic rdg_ready_o, // Buffer takes the reading.
	input wire rsq_pkg::rsq_rdg_t rdg_data_i, // Reading value.
	input wire logic store_pause_i, // Stalls the store write port.
	input wire logic capture_key_i, // Store key press.
	input wire logic arm_cmd_i, // Host arm command.
	input wire logic panel_cnt_we_i, // Panel count entry.
	input wire logic [`RSQ_CNT_W-1:0] panel_cnt_i, // Entered count.
	output logic mem_ind_o, // Memory indicator.
	output logic fetch_valid_o, // Stored reading ready for host.
	input wire logic fetch_ready_i, // Host takes the reading.
	output rsq_pkg::rsq_rdg_t fetch_data_o, // Oldest stored reading.
	output logic [`RSQ_CNT_W-1:0] stored_count_query_o, // Readings stored.
	input wire logic review_key_i, // Recall key press.
	input wire logic review_next_i, // Step to newer reading.
	input wire logic review_prev_i, // Step to older reading.
	output logic [`RSQ_CNT_W-1:0] review_idx_o, // Position under review.
	output rsq_pkg::rsq_rdg_t review_data_o, // Reading under review.
	input wire logic hold_mode_i, // Reading hold enabled.
	input wire logic band_we_i, // Panel band entry.
	input wire logic [`RSQ_BAND_W-1:0] band_i, // Band in 0.01 percent.
	input wire logic init_save_i, // Startup keeps saved band.
	input wire logic [`RSQ_BAND_W-1:0] band_saved_i, // Saved band.
	output logic [`RSQ_BAND_W-1:0] band_o, // Band in use.
	output logic hold_beep_o, // Beep pulse on stable reading.
	output rsq_pkg::rsq_rdg_t hold_value_o, // Frozen reading.
	input wire rsq_pkg::rsq_err_ev_t err_i, // Error recorded.
	input wire logic err_rd_i, // Error queue read.
	input wire logic cls_i, // Clear-status command.
	output logic [`RSQ_ERR_W-1:0] err_code_o, // Last error read out.
	output logic err_ind_o // Error indicator.
);
	rsq_pkg::rsq_state_t s_reg, s_next;
	rsq_pkg::rsq_rdg_t store [`RSQ_STORE_DEPTH];
	logic [`RSQ_ERR_W-1:0] equeue [`RSQ_ERR_DEPTH];
	rsq_pkg::rsq_rdg_t buf_data, fdata_reg, rdata_reg;
	logic buf_valid, st_we, start, rdg_fire, e_we, stable;
	logic [`RSQ_ERR_AW-1:0] e_waddr;
	logic [`RSQ_ERR_W-1:0] e_wdata;

	// Within-band test: |a-b| * 10000 <= band * |a|.
	function automatic logic near(input rsq_pkg::rsq_rdg_t a, input rsq_pkg::rsq_rdg_t b,
		input logic [`RSQ_BAND_W-1:0] band);
		logic signed [`RSQ_RDG_W:0] d;
		logic [`RSQ_RDG_W:0] ad, ax;
		d = `RSQ_RDG_W'(a) - b;
		ad = d[`RSQ_RDG_W] ? `RSQ_RDG_W'(-d) : `RSQ_RDG_W'(d);
		ax = a[`RSQ_RDG_W-1] ? -(`RSQ_RDG_W+1)'(a) : (`RSQ_RDG_W+1)'(a);
		return (48'(ad) * `RSQ_PCT_SCALE) <= (48'(band) * 48'(ax));
	endfunction

	// Flow control: the buffer always drains unless the store port is paused.
	assign start = capture_key_i || arm_cmd_i; // RQ7
	assign rdg_fire = rdg_valid_i && rdg_ready_o;
	assign st_we = buf_valid && !store_pause_i && s_reg.cap_on; // RQ3
	assign stable = (s_reg.hn == `RSQ_HOLD_PREV) && near(rdg_data_i, s_reg.h1, s_reg.band)
		&& near(rdg_data_i, s_reg.h2, s_reg.band); // RQ10

	rsq_fifo #(
		.W(`RSQ_RDG_W),
		.DEPTH(`RSQ_BUF_DEPTH)
	) u_buf (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(start),
		.in_valid_i(rdg_valid_i),
		.in_ready_o(rdg_ready_o),
		.in_data_i(rdg_data_i),
		.out_valid_o(buf_valid),
		.out_ready_i(!store_pause_i),
		.out_data_o(buf_data)
	);

	// Next-state logic for capture, fetch, review, hold and error queue.
	always_comb
	begin
		logic [`RSQ_ERR_AW:0] nxt;
		nxt = '0;
		s_next = s_reg;
		s_next.beep = 1'b0;
		e_we = 1'b0;
		e_waddr = '0;
		e_wdata = err_i.code;
		// Count entry only from the panel, clamped into range.
		if (panel_cnt_we_i) // RQ9
			s_next.cnt = (panel_cnt_i < `RSQ_CNT_MIN) ? `RSQ_CNT_MIN :
				(panel_cnt_i > `RSQ_STORE_DEPTH) ? `RSQ_STORE_DEPTH : panel_cnt_i; // RQ20
		// Capture: store each drained reading until the count is reached.
		if (st_we)
		begin
			s_next.wr = s_reg.wr + 1'b1; // RQ1
			if (s_reg.wr + 1'b1 >= s_reg.cnt)
				s_next.cap_on = 1'b0; // RQ5
		end
		if (fetch_valid_o && fetch_ready_i)
			s_next.rd = s_reg.rd + 1'b1; // RQ8
		// Review steps between oldest and newest.
		if (review_key_i)
			s_next.rev = '0; // RQ6
		else if (review_next_i && (s_reg.rev + 1'b1 < s_reg.wr - s_reg.rd))
			s_next.rev = s_reg.rev + 1'b1; // RQ6
		else if (review_prev_i && s_reg.rev != '0)
			s_next.rev = s_reg.rev - 1'b1; // RQ6
		if (start)
		begin
			s_next.cap_on = 1'b1;
			s_next.wr = '0; // RQ20
			s_next.rd = '0;
			s_next.rev = '0;
		end
		s_next.fvld = !start && (s_reg.wr != s_next.rd);
		// Band load at the first cycle after reset, then panel edits.
		s_next.binit = 1'b1;
		if (!s_reg.binit)
			s_next.band = init_save_i ? band_saved_i : `RSQ_BAND_DEF; // RQ13
		else if (band_we_i)
			s_next.band = band_i;
		// Hold detector on every reading accepted from the source.
		if (!hold_mode_i)
		begin
			s_next.hn = '0;
			s_next.held = 1'b0;
		end
		else if (rdg_fire)
		begin
			s_next.h1 = rdg_data_i;
			s_next.h2 = s_reg.h1;
			if (s_reg.hn != `RSQ_HOLD_PREV)
				s_next.hn = s_reg.hn + 1'b1;
			if (stable && !s_reg.held)
			begin
				s_next.held = 1'b1; // RQ11
				s_next.hval = rdg_data_i;
				s_next.beep = 1'b1;
			end
			else if (s_reg.held && !near(rdg_data_i, s_reg.hval, s_reg.band))
				s_next.held = 1'b0;
		end
		// Error queue: clear first, then read, then record, so a new error survives.
		if (cls_i)
		begin
			s_next.e_head = '0; // RQ19
			s_next.e_cnt = '0;
		end
		else if (err_rd_i)
		begin
			s_next.e_out = (s_reg.e_cnt != '0) ? equeue[s_reg.e_head] : `RSQ_ERR_NONE; // RQ18
			if (s_reg.e_cnt != '0)
			begin
				s_next.e_head = (s_reg.e_head == `RSQ_ERR_DEPTH - 1'b1) ? '0 : s_reg.e_head + 1'b1; // RQ21
				s_next.e_cnt = s_reg.e_cnt - 1'b1; // RQ17
			end
		end
		if (err_i.vld)
		begin
			e_we = 1'b1;
			nxt = (`RSQ_ERR_AW+1)'(s_next.e_head) + (`RSQ_ERR_AW+1)'(s_next.e_cnt);
			if (s_next.e_cnt == `RSQ_ERR_DEPTH)
			begin
				nxt = nxt - 1'b1;
				e_wdata = `RSQ_ERR_OVF; // RQ16
			end
			else
				s_next.e_cnt = s_next.e_cnt + 1'b1; // RQ15
			e_waddr = (nxt >= `RSQ_ERR_DEPTH) ? `RSQ_ERR_AW'(nxt - `RSQ_ERR_DEPTH) : `RSQ_ERR_AW'(nxt);
		end
	end

	// State register; reset empties both queues and restores the count.
	always_ff @(posedge core_clk_i)
		if (!rst_n_i)
		begin
			s_reg <= '0; // RQ2
			s_reg.cnt <= `RSQ_CNT_DEF; // RQ4
			s_reg.band <= `RSQ_BAND_DEF; // RQ12
		end
		else
			s_reg <= s_next;

	// Storage arrays with registered read ports for fetch and review.
	always_ff @(posedge core_clk_i)
	begin
		if (st_we)
			store[s_reg.wr] <= buf_data;
		fdata_reg <= store[s_next.rd];
		rdata_reg <= store[s_next.rd + s_next.rev];
		if (e_we)
			equeue[e_waddr] <= e_wdata;
	end

	// Outputs.
	assign mem_ind_o = s_reg.cap_on; // RQ5
	assign fetch_valid_o = s_reg.fvld;
	assign fetch_data_o = fdata_reg;
	assign stored_count_query_o = s_reg.wr - s_reg.rd; // RQ8
	assign review_idx_o = s_reg.rev;
	assign review_data_o = rdata_reg;
	assign band_o = s_reg.band;
	assign hold_beep_o = s_reg.beep;
	assign hold_value_o = s_reg.hval;
	assign err_code_o = s_reg.e_out;
	assign err_ind_o = s_reg.e_cnt != '0; // RQ14

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_cnt_range;
		s_reg.cnt >= `RSQ_CNT_MIN && s_reg.cnt <= `RSQ_STORE_DEPTH;
	endproperty
	a_cnt_range: assert property (p_cnt_range) else $error("count out of range"); // RQ20
	property p_cnt_def;
		!s_reg.binit && !panel_cnt_we_i |=> s_reg.cnt == `RSQ_CNT_DEF;
	endproperty
	a_cnt_def: assert property (p_cnt_def) else $error("count not default after reset"); // RQ4
	property p_cap_stop;
		st_we && !start && (s_reg.wr + 1'b1 == s_reg.cnt) |=> !mem_ind_o;
	endproperty
	a_cap_stop: assert property (p_cap_stop) else $error("indicator stays on after count"); // RQ5
	property p_cap_clear;
		start |=> stored_count_query_o == '0 && mem_ind_o;
	endproperty
	a_cap_clear: assert property (p_cap_clear) else $error("capture start does not clear"); // RQ20
	property p_count_up;
		st_we && !start && !(fetch_valid_o && fetch_ready_i) |=>
			stored_count_query_o == $past(stored_count_query_o) + 1'b1;
	endproperty
	a_count_up: assert property (p_count_up) else $error("stored count not raised"); // RQ8
	property p_cls;
		cls_i && !err_i.vld |=> !err_ind_o;
	endproperty
	a_cls: assert property (p_cls) else $error("clear-status leaves errors"); // RQ19
	property p_ovf;
		err_i.vld && s_reg.e_cnt == `RSQ_ERR_DEPTH && !err_rd_i && !cls_i |=> s_reg.e_cnt == `RSQ_ERR_DEPTH;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow changed queue depth"); // RQ16
	property p_empty_rd;
		err_rd_i && !err_ind_o && !cls_i |=> err_code_o == `RSQ_ERR_NONE;
	endproperty
	a_empty_rd: assert property (p_empty_rd) else $error("empty read not no-error code"); // RQ18
	property p_beep;
		hold_beep_o |-> s_reg.held ##1 !hold_beep_o;
	endproperty
	a_beep: assert property (p_beep) else $error("beep not single pulse"); // RQ11
	property p_band_def;
		!s_reg.binit && !init_save_i |=> band_o == `RSQ_BAND_DEF;
	endproperty
	a_band_def: assert property (p_band_def) else $error("band not default at start"); // RQ12

	c_full_cap: cover property (st_we && s_reg.wr == `RSQ_STORE_DEPTH - 1'b1);
	c_err_ovf: cover property (err_i.vld && s_reg.e_cnt == `RSQ_ERR_DEPTH);
	c_hold: cover property (hold_beep_o);
endmodule

// ### rsq_host_model.sv
/*
 * Host model: takes stored readings off the fetch port, promptly or with stalls.
 * Assumes one clock; the bench enables it only while it wants readings.
 */
`timescale 1ns/1ps
module rsq_host_model (
	input wire logic core_clk_i, // System clock.
	input wire logic en_i, // Host is fetching.
	input wire logic slow_i, // Stall every other cycle.
	input wire logic fetch_valid_i, // Reading offered.
	input wire rsq_pkg::rsq_rdg_t fetch_data_i, // Offered reading.
	output logic fetch_ready_o // Host takes the reading.
);
	rsq_pkg::rsq_rdg_t got[$];
	logic ph = 1'b0;
	initial fetch_ready_o = 1'b0;
	// A reading is logged at the edge that takes it; ready moves only after that edge.
	always @(posedge core_clk_i)
	begin
		if (fetch_valid_i === 1'b1 && fetch_ready_o)
			got.push_back(fetch_data_i);
		ph <= ~ph;
		fetch_ready_o <= en_i && (!slow_i || ph);
	end
endmodule

// ### tb_top.sv
/*
 * Self-checking bench: error queue rows, overflow, hold detection, capture through the buffer, review, fetch,
 * clear-status, band entry and resets in mid-run.
 * Assumes the design files and rsq_host_model are compiled first.
 */
`timescale 1ns/1ps
`include "rsq_defs.svh"
module tb_top;
	typedef struct packed {logic rd; logic [15:0] code; logic [15:0] ec; logic ei;} row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rv = 1'b0;
	logic rr, pause, mem, fv, fr, hm, beep, eind, en, slow;
	logic [8:0] pul = '0;
	logic isave = 1'b0;
	logic [13:0] bset = 14'h0014;
	logic [10:0] pcnt, scnt, ridx;
	logic [13:0] band;
	logic [15:0] ecode;
	rsq_pkg::rsq_rdg_t rd, fd, rdat, hval;
	rsq_pkg::rsq_err_ev_t err;
	int mismatches = 0;
	int n_checks = 0;
	int i, nb;
	row_t rows[5] = '{'{1'b0, 16'h0101, 16'h0000, 1'b1}, '{1'b0, 16'h0102, 16'h0000, 1'b1},
		'{1'b1, 16'h0000, 16'h0101, 1'b1}, '{1'b1, 16'h0000, 16'h0102, 1'b0}, '{1'b1, 16'h0000, 16'h0000, 1'b0}};
	initial {pause, hm, en, slow, pcnt, rd, err} = '0;
	// Clock at 200 MHz.
	always #2.5 clk = ~clk;
	rsq_top rsq_top_i (.core_clk_i(clk), .rst_n_i(rst_n), .rdg_valid_i(rv), .rdg_ready_o(rr),
		.rdg_data_i(rd), .store_pause_i(pause), .capture_key_i(pul[0]), .arm_cmd_i(pul[1]),
		.panel_cnt_we_i(pul[2]), .panel_cnt_i(pcnt), .mem_ind_o(mem), .fetch_valid_o(fv),
		.fetch_ready_i(fr), .fetch_data_o(fd), .stored_count_query_o(scnt), .review_key_i(pul[3]),
		.review_next_i(pul[4]), .review_prev_i(pul[5]), .review_idx_o(ridx), .review_data_o(rdat),
		.hold_mode_i(hm), .band_we_i(pul[7]), .band_i(bset), .init_save_i(isave),
		.band_saved_i(bset), .band_o(band), .hold_beep_o(beep), .hold_value_o(hval),
		.err_i(err), .err_rd_i(pul[6]), .cls_i(pul[8]), .err_code_o(ecode), .err_ind_o(eind));
	rsq_host_model rsq_host_model_i (.core_clk_i(clk), .en_i(en), .slow_i(slow), .fetch_valid_i(fv),
		.fetch_data_i(fd), .fetch_ready_o(fr));
	// Ends the run with the counts and the verdict.
	task stop_test;
		$display("Counts: %0d compared, %0d wrong", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string n, input logic [23:0] e, input logic [23:0] g);
		n_checks++;
		if (e !== g)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// A wait that runs out is a mismatch and ends the run.
	task tmo(input int k);
		if (k >= 200)
		begin
			mismatches++;
			stop_test();
		end
	endtask
	// Holds reset for four cycles and returns just after the second edge after its release.
	task reset_dut;
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// One-cycle pulse on a control input; returns just after the edge that follows it.
	task pulse(input int b);
		@(posedge clk);
		pul[b] <= 1'b1;
		@(posedge clk);
		pul <= '0;
		#1;
	endtask
	task epush(input logic [15:0] c);
		@(posedge clk);
		err <= '{1'b1, c};
		@(posedge clk);
		err <= '0;
		#1;
	endtask
	// Offers a reading and returns at the edge that takes it, valid still high.
	task send(input int v);
		int k;
		rd <= v[23:0];
		rv <= 1'b1;
		for (k = 0; k < 200; k++)
		begin
			@(negedge clk);
			if (rr === 1'b1)
				break;
		end
		tmo(k);
		@(posedge clk);
	endtask
	task wait_cnt(input logic [10:0] n);
		int k;
		for (k = 0; k < 200 && scnt !== n; k++)
			@(negedge clk);
		tmo(k);
		@(negedge clk);
	endtask
	// Counts beeps over twelve cycles after three readings.
	task hold3(input int a, input int b, input int c);
		send(a);
		send(b);
		send(c);
		rv <= 1'b0;
		nb = 0;
		repeat (12)
		begin
			@(negedge clk);
			nb += (beep === 1'b1);
		end
	endtask
	initial
	begin
		reset_dut();
		chk("mem_ind", 0, mem);
		chk("stored", 0, scnt);
		chk("err_ind", 0, eind);
		chk("band", 10, band);
		// Ordinary error queue traffic from the table.
		foreach (rows[j])
		begin
			if (rows[j].rd)
			begin
				pulse(6);
				chk("err_code", rows[j].ec, ecode);
			end
			else
				epush(rows[j].code);
			chk("err_ind", rows[j].ei, eind);
		end
		// Twenty-one errors: the newest entry turns into the overflow code.
		for (i = 1; i <= 21; i++)
			epush(i[15:0]);
		for (i = 1; i <= 20; i++)
		begin
			pulse(6);
			chk("err_code", (i == 20) ? `RSQ_ERR_OVF : i, ecode);
		end
		chk("err_ind", 0, eind);
		// Hold: boundary of the band beeps once; one step outside does not.
		hm <= 1'b1;
		hold3(5000, 5005, 5000);
		chk("beeps", 1, nb);
		chk("hold_value", 5000, hval);
		hm <= 1'b0;
		@(posedge clk);
		hm <= 1'b1;
		hold3(5000, 5006, 5000);
		chk("beeps", 0, nb);
		// Capture sixteen through a stalled buffer, which must refuse a seventeenth.
		pcnt <= 11'd16;
		pulse(2);
		pulse(0);
		chk("mem_ind", 1, mem);
		pause <= 1'b1;
		for (i = 0; i < 16; i++)
			send(256 + i);
		#1;
		chk("rdg_ready", 0, rr);
		@(posedge clk);
		rv <= 1'b0;
		pause <= 1'b0;
		wait_cnt(16);
		chk("stored", 16, scnt);
		chk("mem_ind", 0, mem);
		// Review starts at the oldest; a step back at the oldest is ignored.
		pulse(3);
		chk("review_idx", 0, ridx);
		chk("review_data", 256, rdat);
		pulse(4);
		chk("review_data", 257, rdat);
		pulse(5);
		pulse(5);
		chk("review_idx", 0, ridx);
		// The host fetches with stalls, oldest first.
		slow <= 1'b1;
		en <= 1'b1;
		wait_cnt(0);
		en <= 1'b0;
		chk("fetched", 16, rsq_host_model_i.got.size());
		for (i = 0; i < 16 && i < rsq_host_model_i.got.size(); i++)
			chk("fetch_data", 256 + i, rsq_host_model_i.got[i]);
		// Arm with a count entered as zero, which is raised to one.
		pcnt <= 11'd0;
		pulse(2);
		pulse(1);
		chk("mem_ind", 1, mem);
		send(7);
		send(8);
		rv <= 1'b0;
		wait_cnt(1);
		repeat (4) @(negedge clk);
		chk("stored", 1, scnt);
		chk("mem_ind", 0, mem);
		// Clear-status empties the queue; a read then gives the no-error code.
		epush(16'h0033);
		epush(16'h0034);
		chk("err_ind", 1, eind);
		pulse(8);
		chk("err_ind", 0, eind);
		pulse(6);
		chk("err_code", `RSQ_ERR_NONE, ecode);
		// Panel band entry, then a reset that keeps the saved band.
		pulse(7);
		chk("band", 14'h0014, band);
		isave <= 1'b1;
		bset <= 14'h0028;
		reset_dut();
		chk("band", 14'h0028, band);
		chk("stored", 0, scnt);
		chk("mem_ind", 0, mem);
		// A reset without saving restores the default band and the default count of one hundred.
		isave <= 1'b0;
		reset_dut();
		chk("band", `RSQ_BAND_DEF, band);
		pulse(0);
		for (i = 0; i < 100; i++)
			send(i);
		rv <= 1'b0;
		wait_cnt(100);
		chk("stored", 100, scnt);
		chk("mem_ind", 0, mem);
		stop_test();
	end
endmodule
